// >>> ral_regs.svh
// register offsets, field positions and reset values for the address latch block
`ifndef RAL_REGS_SVH
`define RAL_REGS_SVH
// ==========================================================
// byte offsets (configuration registers 3..6, status of own choosing)
`define RAL_OFF_CFG3      12'h008
`define RAL_OFF_CFG4      12'h00c
`define RAL_OFF_CFG5      12'h010
`define RAL_OFF_CFG6      12'h014
`define RAL_OFF_STATUS    12'h020
// ==========================================================
// field positions
`define RAL_CFG3_ENH_BIT  15
`define RAL_CFG4_LAT_BIT  3
`define RAL_CFG6_SRC_BIT  5
// ==========================================================
// reset values
`define RAL_CFG3_RST      16'h0000
`define RAL_CFG4_RST      16'h0000
`define RAL_CFG6_RST      16'h0000
`define RAL_ADDR_RST      6'h00
// ==========================================================
// bus answer codes
`define RAL_RESP_OKAY     2'b00
`define RAL_RESP_SLVERR   2'b10
`endif

// >>> ral_pkg.sv
// types shared by the address latch block
package ral_pkg;
	// terminal address with parity, parity in bit 0
	typedef struct packed {
		logic [4:0] addr;
		logic       parity;
	} ral_taddr_type;
	// incoming command summary from the protocol engine
	typedef struct packed {
		logic       valid;
		logic [4:0] addr;
	} ral_cmd_type;
endpackage

// >>> ral_parity_chk.sv
// odd parity checker and command acceptance for the terminal address
`timescale 1ns/1ps
module ral_parity_chk (
	// terminal address
	input  wire ral_pkg::ral_taddr_type taddr,
	// command under test
	input  wire ral_pkg::ral_cmd_type   cmd,
	// results
	output logic                        parity_ok,
	output logic                        accept
);
	import ral_pkg::*;
	// ==========================================================
	// checks
	// odd number of ones over addr and parity
	always_comb begin
		parity_ok = ^{taddr.addr, taddr.parity};
		if (!cmd.valid) begin
			accept = 1'b0;
		end else if (cmd.addr == 5'h1f) begin
			accept = 1'b1;
		end else begin
			accept = parity_ok && (cmd.addr == taddr.addr);
		end
	end
endmodule

// >>> ral_addr_latch.sv
// terminal address select and latch with axi4-lite configuration registers
//
// Summary of operation
// - respond to own address only with odd parity
// - broadcast accepted regardless of parity
// - latch pin low: straps used transparently
// - pin rising edge captures strap values
// - pin high: only host sequence updates address
// - cfg6 bit 5 selects source, reset straps
// - host source: d5..d1 address, d0 parity
// - strap source ignores cfg5 data bits
// - no transparent memory mode, strobe unused
`timescale 1ns/1ps
`include "ral_regs.svh"
module ral_addr_latch (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write address
	input  wire logic [11:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// strap pins
	input  wire logic                  term_addr_bit4,
	input  wire logic                  term_addr_bit3,
	input  wire logic                  term_addr_bit2,
	input  wire logic                  term_addr_bit1,
	input  wire logic                  term_addr_bit0,
	input  wire logic                  term_addr_parity,
	input  wire logic                  term_addr_latch_ctl,
	input  wire logic                  no_wait_select,
	// command from protocol engine
	input  wire ral_pkg::ral_cmd_type  cmd,
	// results
	output ral_pkg::ral_taddr_type     live_addr,
	output logic                       addr_parity_ok,
	output logic                       cmd_accept,
	output logic                       zero_wait_mode,
	output logic                       ext_mem_write_strobe
);
	import ral_pkg::*;

	// ==========================================================
	// state
	typedef enum logic [1:0] {ST_IDLE, ST_RESP} ral_wst_type;
	typedef struct packed {
		logic          awready;   // write address taken
		logic          wready;    // write data taken
		logic [11:0]   awaddr;    // held write address
		logic          aw_have;   // address held
		logic [31:0]   wdata;     // held write data
		logic [3:0]    wstrb;     // held strobes
		logic          w_have;    // data held
		ral_wst_type   wst;       // write response state
		logic [1:0]    bresp;     // write answer code
		logic          arready;   // read address taken
		logic          rvalid;    // read answer valid
		logic [31:0]   rdata;     // read data
		logic [1:0]    rresp;     // read answer code
		logic [15:0]   cfg3;      // enhanced mode enable lives here
		logic [15:0]   cfg4;      // latch arm bit lives here
		logic [15:0]   cfg6;      // source select lives here
		logic          pin_q;     // previous latch pin level
		ral_taddr_type held;      // latched address
		ral_taddr_type live;      // address presented to the engine
		logic          par_ok;    // registered parity result
		logic          accept;    // registered acceptance
		logic          zw;        // registered zero-wait mode
		logic          bvalid;    // write answer valid
		logic          strobe;    // memory write strobe, never driven active
	} ral_state_type;

	ral_state_type s_q, s_d;     // current and next state
	ral_taddr_type strap;        // strap pins gathered
	ral_taddr_type chk_in;       // address fed to the checker
	logic          chk_par_ok;   // checker parity result
	logic          chk_accept;   // checker acceptance
	logic          wr_fire;      // write carried out this cycle
	logic [31:0]   rd_word;      // read mux output

	assign strap = '{addr: {term_addr_bit4, term_addr_bit3, term_addr_bit2,
		term_addr_bit1, term_addr_bit0}, parity: term_addr_parity};

	// ==========================================================
	// checker, fed with next live address so results align
	ral_parity_chk u_chk (
		.taddr     (chk_in),
		.cmd       (cmd),
		.parity_ok (chk_par_ok),
		.accept    (chk_accept)
	);

	// ==========================================================
	// read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`RAL_OFF_CFG3:   rd_word = {16'h0000, s_q.cfg3};
			`RAL_OFF_CFG4:   rd_word = {16'h0000, s_q.cfg4};
			`RAL_OFF_CFG5:   rd_word = {26'h0000000, s_q.held};
			`RAL_OFF_CFG6:   rd_word = {16'h0000, s_q.cfg6};
			// status: live address, parity ok, pin, zero wait
			`RAL_OFF_STATUS: rd_word = {22'h000000, s_q.zw, term_addr_latch_ctl,
				s_q.par_ok, 1'b0, s_q.live};
			default:         rd_word = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// a write completes once both channels are held
	assign wr_fire = (s_q.wst == ST_IDLE) && s_q.aw_have && s_q.w_have;

	// ==========================================================
	// next terminal address, kept apart from the state process so the
	// checker results come back without a combinational loop
	always_comb begin
		chk_in = s_q.live;
		if (!term_addr_latch_ctl) begin
			chk_in = strap;
		end else if (!s_q.pin_q) begin
			chk_in = strap;
		end else if (wr_fire && s_q.awaddr == `RAL_OFF_CFG5 && s_q.wstrb[0] &&
			s_q.cfg3[`RAL_CFG3_ENH_BIT] && s_q.cfg4[`RAL_CFG4_LAT_BIT]) begin
			if (s_q.cfg6[`RAL_CFG6_SRC_BIT]) begin
				chk_in = '{addr: s_q.wdata[5:1], parity: s_q.wdata[0]};
			end else begin
				chk_in = strap;
			end
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.awready = 1'b0;
		s_d.wready  = 1'b0;
		s_d.arready = 1'b0;
		s_d.pin_q   = term_addr_latch_ctl;
		// write channels taken in either order, one write at a time
		if (s_axi_awvalid && !s_q.aw_have && !s_q.awready && s_q.wst == ST_IDLE) begin
			s_d.awready = 1'b1;
			s_d.aw_have = 1'b1;
			s_d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_have && !s_q.wready && s_q.wst == ST_IDLE) begin
			s_d.wready = 1'b1;
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb  = s_axi_wstrb;
		end
		case (s_q.wst)
			ST_IDLE: begin
				if (wr_fire) begin
					s_d.aw_have = 1'b0;
					s_d.w_have  = 1'b0;
					s_d.wst   = ST_RESP;
					s_d.bresp = `RAL_RESP_OKAY;
					// low half only, byte lanes honoured
					case (s_q.awaddr)
						`RAL_OFF_CFG3: begin
							if (s_q.wstrb[0]) s_d.cfg3[7:0]  = s_q.wdata[7:0];
							if (s_q.wstrb[1]) s_d.cfg3[15:8] = s_q.wdata[15:8];
						end
						`RAL_OFF_CFG4: begin
							if (s_q.wstrb[0]) s_d.cfg4[7:0]  = s_q.wdata[7:0];
							if (s_q.wstrb[1]) s_d.cfg4[15:8] = s_q.wdata[15:8];
						end
						`RAL_OFF_CFG6: begin
							if (s_q.wstrb[0]) s_d.cfg6[7:0]  = s_q.wdata[7:0];
							if (s_q.wstrb[1]) s_d.cfg6[15:8] = s_q.wdata[15:8];
						end
						`RAL_OFF_CFG5: ;  // handled by latch logic below
						default: s_d.bresp = `RAL_RESP_SLVERR;
					endcase
				end
			end
			ST_RESP: begin
				if (s_axi_bready) begin
					s_d.wst = ST_IDLE;
				end
			end
			default: s_d.wst = ST_IDLE;
		endcase
		// read: one at a time, answer next cycle
		if (s_q.rvalid) begin
			if (s_axi_rready) begin
				s_d.rvalid = 1'b0;
			end
		end else if (s_axi_arvalid && !s_q.arready) begin
			s_d.arready = 1'b1;
			s_d.rvalid  = 1'b1;
			s_d.rdata   = rd_word;
			s_d.rresp   = (s_axi_araddr == `RAL_OFF_CFG3 || s_axi_araddr == `RAL_OFF_CFG4 ||
				s_axi_araddr == `RAL_OFF_CFG5 || s_axi_araddr == `RAL_OFF_CFG6 ||
				s_axi_araddr == `RAL_OFF_STATUS) ? `RAL_RESP_OKAY : `RAL_RESP_SLVERR;
		end
		// address worked out above; held value otherwise unchanged
		s_d.held   = chk_in;
		s_d.live   = chk_in;
		s_d.zw     = !no_wait_select;
		s_d.par_ok = chk_par_ok;
		s_d.accept = chk_accept;
		s_d.bvalid = (s_d.wst == ST_RESP);
		s_d.strobe = 1'b0;
	end

	// ==========================================================
	// registers, synchronous active-low reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q        <= '0;
			s_q.wst    <= ST_IDLE;
			s_q.cfg3   <= `RAL_CFG3_RST;
			s_q.cfg4   <= `RAL_CFG4_RST;
			s_q.cfg6   <= `RAL_CFG6_RST;
			s_q.held   <= `RAL_ADDR_RST;
			s_q.live   <= `RAL_ADDR_RST;
			s_q.pin_q  <= 1'b1;  // no false edge straight after reset
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs, all from flip-flops
	assign s_axi_awready        = s_q.awready;
	assign s_axi_wready         = s_q.wready;
	assign s_axi_bvalid         = s_q.bvalid;
	assign s_axi_bresp          = s_q.bresp;
	assign s_axi_arready        = s_q.arready;
	assign s_axi_rvalid         = s_q.rvalid;
	assign s_axi_rdata          = s_q.rdata;
	assign s_axi_rresp          = s_q.rresp;
	assign live_addr            = s_q.live;
	assign addr_parity_ok       = s_q.par_ok;
	assign cmd_accept           = s_q.accept;
	assign zero_wait_mode       = s_q.zw;
	// transparent memory mode absent; strobe is a constant-inactive flop
	assign ext_mem_write_strobe = s_q.strobe;
endmodule

// >>> ral_latch_properties.sv
// concurrent checks on the terminal address latch ports
`timescale 1ns/1ps
module ral_latch_props
	import ral_pkg::*;
(
	// clock and reset
	input wire logic                   aclk,
	input wire logic                   aresetn,
	// straps, latch pin, write answer
	input wire logic                   term_addr_bit4,
	input wire logic                   term_addr_bit3,
	input wire logic                   term_addr_bit2,
	input wire logic                   term_addr_bit1,
	input wire logic                   term_addr_bit0,
	input wire logic                   term_addr_parity,
	input wire logic                   term_addr_latch_ctl,
	input wire logic                   s_axi_bvalid,
	// command and results
	input wire ral_pkg::ral_cmd_type   cmd,
	input wire ral_pkg::ral_taddr_type live_addr,
	input wire logic                   addr_parity_ok,
	input wire logic                   cmd_accept,
	input wire logic                   ext_mem_write_strobe
);
	// ==========================================
	// strap word in live address layout
	logic [5:0] straps;
	assign straps = {term_addr_bit4, term_addr_bit3, term_addr_bit2,
		term_addr_bit1, term_addr_bit0, term_addr_parity};
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// pin low then high
	sequence s_rise;
		!term_addr_latch_ctl ##1 term_addr_latch_ctl;
	endsequence
	// pin high long enough that a capture has settled
	sequence s_held;
		term_addr_latch_ctl [*3];
	endsequence
	a_strobe_idle: assert property (ext_mem_write_strobe == 1'b0)
		else $error("memory write strobe moved");
	a_parity_flag: assert property (addr_parity_ok == ^live_addr)
		else $error("parity flag wrong");
	a_strap_follow: assert property (!term_addr_latch_ctl |=> live_addr == $past(straps))
		else $error("straps not followed");
	a_edge_capture: assert property (s_rise |=> live_addr == $past(straps))
		else $error("rising edge capture wrong");
	a_host_hold: assert property (s_held ##0 !$rose(s_axi_bvalid) |-> $stable(live_addr))
		else $error("address moved without event");
	a_broadcast_in: assert property (cmd.valid && cmd.addr == 5'h1f |=> cmd_accept)
		else $error("broadcast refused");
	a_accept_cause: assert property (cmd_accept |-> $past(cmd.valid) && ($past(cmd.addr) == 5'h1f
		|| ($past(cmd.addr) == live_addr.addr && addr_parity_ok)))
		else $error("accept without cause");
	a_own_accept: assert property ($past(aresetn) && $past(cmd.valid) && addr_parity_ok
		&& $past(cmd.addr) == live_addr.addr |-> cmd_accept)
		else $error("own command refused");
endmodule

// >>> ral_strap_model.sv
// board straps and wait select seen by the latch block
`timescale 1ns/1ps
module ral_strap_model
	import ral_pkg::*;
(
	// clock
	input wire logic              aclk,
	// board levels
	output ral_pkg::ral_taddr_type straps,
	output logic                   term_addr_latch_ctl,
	output logic                   no_wait_select
);
	// power up transparent, normal timing
	initial begin
		straps = '0;
		term_addr_latch_ctl = 1'b0;
		no_wait_select = 1'b1;
	end
	// board change lands just after an edge, levels held after
	task automatic set(input ral_taddr_type t, input logic pin, input logic nw);
		@(posedge aclk);
		straps <= t;
		term_addr_latch_ctl <= pin;
		no_wait_select <= nw; // high waits, low zero wait
	endtask
endmodule

// >>> ral_testbench.sv
// self-checking bench for the terminal address latch
`timescale 1ns/1ps
`include "ral_regs.svh"
module testbench;
	import ral_pkg::*;
	// ==========================================
	// bus, pins and bookkeeping
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        term_addr_latch_ctl, no_wait_select, addr_parity_ok, cmd_accept;
	logic        zero_wait_mode, ext_mem_write_strobe;
	ral_cmd_type   cmd = '0;
	ral_taddr_type straps, live_addr, ta, tb;
	logic [4:0]    a;
	logic [33:0]   expq[$];
	int            fail_count = 0, n_compared = 0, cyc = 0;
	always #2 aclk = ~aclk;
	ral_strap_model u_ral_strap_model (.aclk, .straps, .term_addr_latch_ctl, .no_wait_select);
	ral_addr_latch u_ral_addr_latch (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.term_addr_bit4(straps.addr[4]), .term_addr_bit3(straps.addr[3]),
		.term_addr_bit2(straps.addr[2]), .term_addr_bit1(straps.addr[1]),
		.term_addr_bit0(straps.addr[0]), .term_addr_parity(straps.parity),
		.term_addr_latch_ctl, .no_wait_select, .cmd, .live_addr, .addr_parity_ok,
		.cmd_accept, .zero_wait_mode, .ext_mem_write_strobe);
	// ==========================================
	// compare and close
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("mismatch at %0t: seen %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic final_report();
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// hang guard, run needs well under this
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			final_report();
		end
	end
	// watcher: oldest note against each read answer
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
		end
	end
	// status word the block should show for a live address
	function automatic logic [31:0] sts(input ral_taddr_type t);
		return {22'h0, ~no_wait_select, term_addr_latch_ctl, ^t, 1'b0, t};
	endfunction
	// write: both channels offered, each dropped when taken
	task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
		logic ak, wk;
		ak = 1'b0;
		wk = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ak && wk)) begin
			@(posedge aclk);
			if (s_axi_awready && !ak) begin
				ak = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~ad;
			end
			if (s_axi_wready && !wk) begin
				wk = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check({32'h0, s_axi_bresp}, {32'h0, er});
	endtask
	// read: expectation queued, watcher compares
	task automatic rd(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		expq.push_back({er, d});
		do begin
			@(posedge aclk);
			if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~ad;
			end
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	// one command, acceptance looked at one cycle on
	task automatic cmdt(input logic [4:0] ca, input logic e);
		@(posedge aclk);
		cmd <= {1'b1, ca};
		@(posedge aclk);
		cmd <= '0;
		#1;
		check({33'h0, cmd_accept}, {33'h0, e});
	endtask
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'h9d04));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`RAL_OFF_CFG3, 32'h0, `RAL_RESP_OKAY);
		rd(`RAL_OFF_CFG6, 32'h0, `RAL_RESP_OKAY);
		$display("reset values done");
		repeat (4) begin
			ta = 6'($urandom);
			u_ral_strap_model.set(ta, 1'b0, 1'($urandom));
			repeat (2) @(posedge aclk);
			check({28'h0, live_addr}, {28'h0, ta});
			check({32'h0, zero_wait_mode, addr_parity_ok}, {32'h0, ~no_wait_select, ^ta});
			rd(`RAL_OFF_STATUS, sts(ta), `RAL_RESP_OKAY);
		end
		check({33'h0, ext_mem_write_strobe}, 34'h0);
		$display("transparent straps done");
		ta = 6'($urandom);
		u_ral_strap_model.set(ta, 1'b1, 1'b1);
		u_ral_strap_model.set(~ta, 1'b1, 1'b1);
		rd(`RAL_OFF_STATUS, sts(ta), `RAL_RESP_OKAY);
		$display("edge capture done");
		// load register written before enable and arm must not move the address
		wr(`RAL_OFF_CFG5, 32'h0, `RAL_RESP_OKAY);
		rd(`RAL_OFF_STATUS, sts(ta), `RAL_RESP_OKAY);
		// host sequence: enable, arm, then write the load register
		wr(`RAL_OFF_CFG3, 32'h8000, `RAL_RESP_OKAY);
		wr(`RAL_OFF_CFG4, 32'h0008, `RAL_RESP_OKAY);
		tb = 6'($urandom);
		u_ral_strap_model.set(tb, 1'b1, 1'b1);
		rd(`RAL_OFF_STATUS, sts(ta), `RAL_RESP_OKAY);
		wr(`RAL_OFF_CFG5, $urandom, `RAL_RESP_OKAY);
		rd(`RAL_OFF_STATUS, sts(tb), `RAL_RESP_OKAY);
		$display("host strap load done");
		wr(`RAL_OFF_CFG6, 32'h20, `RAL_RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			a = 5'($urandom % 31);
			ta = {a, ~^a ^ k[0]};
			wr(`RAL_OFF_CFG5, {26'($urandom), ta}, `RAL_RESP_OKAY);
			rd(`RAL_OFF_STATUS, sts(ta), `RAL_RESP_OKAY);
			cmdt(a, !k[0]);
			cmdt(5'h1f, 1'b1);
			cmdt(5'((a + 5'h01) % 31), 1'b0);
		end
		$display("host data load done");
		wr(12'h040, 32'h1, `RAL_RESP_SLVERR);
		rd(12'h040, 32'h0, `RAL_RESP_SLVERR);
		$display("unmapped access done");
		final_report();
	end
endmodule
bind ral_addr_latch ral_latch_props u_ral_latch_props (.aclk, .aresetn, .term_addr_bit4,
	.term_addr_bit3, .term_addr_bit2, .term_addr_bit1, .term_addr_bit0, .term_addr_parity,
	.term_addr_latch_ctl, .s_axi_bvalid, .cmd, .live_addr, .addr_parity_ok, .cmd_accept,
	.ext_mem_write_strobe);
